// ### rtl/alarm_router_pkg.sv
package alarm_router_pkg;

    // Source select codes for every control and aux output
    localparam logic [4:0] SRC_NONE     = 5'h00;
    localparam logic [4:0] SRC_HEAT     = 5'h01;
    localparam logic [4:0] SRC_COOL     = 5'h02;
    localparam logic [4:0] SRC_ALM1     = 5'h03;
    localparam logic [4:0] SRC_ALM4     = 5'h06;
    localparam logic [4:0] SRC_HTR      = 5'h07;
    localparam logic [4:0] SRC_HBRK     = 5'h08;
    localparam logic [4:0] SRC_HSHT     = 5'h09;
    localparam logic [4:0] SRC_INERR    = 5'h0a;
    localparam logic [4:0] SRC_RSPERR   = 5'h0b;
    localparam logic [4:0] SRC_PEND     = 5'h0c;
    localparam logic [4:0] SRC_RUN      = 5'h0d;
    localparam logic [4:0] SRC_COMB     = 5'h0e;
    localparam logic [4:0] SRC_WORK1    = 5'h0f;
    localparam logic [4:0] SRC_WORK8    = 5'h16;

    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_HSCFG   = 8'h04;
    localparam logic [7:0] ADDR_LOOPT   = 8'h08;
    localparam logic [7:0] ADDR_LOOPLB  = 8'h0c;
    localparam logic [7:0] ADDR_CSEL    = 8'h10;
    localparam logic [7:0] ADDR_ASEL    = 8'h14;
    localparam logic [7:0] ADDR_STATUS  = 8'h18;

    // CTRL bit positions
    localparam int CTRL_LATCH   = 0;
    localparam int CTRL_HSUSE   = 1;
    localparam int CTRL_HCOOL   = 2;
    localparam int CTRL_HASOUT2 = 3;
    localparam int CTRL_AUX4    = 4;
    localparam int CTRL_PROG    = 5;
    localparam int CTRL_LOGIC   = 6;
    localparam int CTRL_HBFIT   = 7;
    localparam int CTRL_FKEYLAT = 8;
    localparam int CTRL_EVLAT   = 9;
    localparam int CTRL_OUTTYP  = 16;

    // Reset values; currents in 0.1 A, levels in 0.1 units
    localparam logic [31:0] CTRL_RST    = 32'h0000_0002;
    localparam logic [9:0]  HS_MAX      = 10'h1f4;
    localparam logic [9:0]  HSHYST_RST  = 10'h001;
    localparam logic [9:0]  HSHYST_MIN  = 10'h001;
    localparam logic [13:0] LOOPT_RST   = 14'h0000;
    localparam logic [13:0] LOOPT_MAX   = 14'h270f;
    localparam logic [13:0] LBLEVEL_RST = 14'h0050;
    localparam logic [13:0] LBBAND_RST  = 14'h001e;
    localparam logic [13:0] LB_MAX      = 14'h270f;
    localparam logic [7:0]  MASK_RST    = 8'h31;
    localparam logic [3:0]  LBTYPE      = 4'hc;

    // Level codes of the operating mode
    localparam logic [2:0] LVL_INIT     = 3'h2;
    localparam logic [2:0] LVL_CALIB    = 3'h5;

    localparam logic [1:0] RESP_OKAY    = 2'b00;
    localparam logic [1:0] RESP_SLVERR  = 2'b10;

endpackage

// ### rtl/alarm_latch_output_router.sv
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module alarm_latch_output_router
    import alarm_router_pkg::*;
#(
    parameter int TICKS_PER_SEC = 20
)(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        sampleTick,
    input  wire logic        heatCtrl,
    input  wire logic        coolCtrl,
    input  wire logic [3:0]  alarmIn,
    input  wire logic        heaterAlarm,
    input  wire logic        heaterBreakAlarm,
    input  wire logic        heaterShortRaw,
    input  wire logic        inputErrorFlag,
    input  wire logic        remoteSetpointErrorFlag,
    input  wire logic        programEnd,
    input  wire logic        runFlag,
    input  wire logic [7:0]  workBitSource,
    input  wire logic [9:0]  heaterCurrent,
    input  wire logic [13:0] deviation,
    input  wire logic [3:0]  alarm1Type,
    input  wire logic [2:0]  operLevel,
    input  wire logic        functionKey,
    input  wire logic [5:0]  eventIn,
    output logic [1:0]       ctrlOut,
    output logic [3:0]       auxOut,
    output logic             heaterShortAlarm,
    output logic             loopBreakAlarm,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    import alarm_router_pkg::*;

    logic [31:0] ctrlFf;
    logic [31:0] hsCfgFf;
    logic [13:0] loopTimeFf;
    logic [31:0] loopLbFf;
    logic [9:0]  ctrlSelFf;
    logic [19:0] auxSelFf;
    logic        awHeldFf;
    logic        wHeldFf;
    logic [7:0]  awAddrFf;
    logic [31:0] wDataFf;
    logic [3:0]  wStrbFf;
    logic        latchFf;
    logic        hsStateFf;
    logic [13:0] secCntFf;
    logic [13:0] tickCntFf;
    logic [13:0] lbRefFf;
    logic        lbArmedFf;
    logic        lbFf;
    logic [1:0]  ctrlOutFf;
    logic [3:0]  auxOutFf;
    logic [1:0]  fkSyncFf;
    logic [1:0]  fkSync2Ff;
    logic [5:0]  evSyncFf;
    logic [5:0]  evSync2Ff;
    logic        fkPrevFf;
    logic [5:0]  evPrevFf;

    logic        doWrite;
    logic        wrErr;
    logic        clearLatch;
    logic        levelClear;
    logic        hsUse;
    logic        hsRaw;
    logic [7:0]  combFlags;
    logic        combAlarm;
    logic [9:0]  hsHyst;
    logic [5:0]  evRole;
    logic [5:0]  outType;

    // Pin synchronisers; first stage read only by second
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            fkSyncFf  <= 2'h0;
            evSyncFf  <= 6'h00;
            fkSync2Ff <= 2'h0;
            evSync2Ff <= 6'h00;
        end
        else
        begin
            fkSyncFf  <= {fkSyncFf[0], functionKey};
            evSyncFf  <= eventIn;
            evSync2Ff <= evSyncFf;
            fkSync2Ff <= fkSyncFf;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            fkPrevFf <= 1'b0;
            evPrevFf <= 6'h00;
        end
        else
        begin
            fkPrevFf <= fkSync2Ff[1];
            evPrevFf <= evSync2Ff;
        end
    end

    // AXI4-Lite write: address and data taken in either order
    assign s_axi_awready = !awHeldFf && !s_axi_bvalid;
    assign s_axi_wready  = !wHeldFf && !s_axi_bvalid;
    assign doWrite       = awHeldFf && wHeldFf;
    assign wrErr = (awAddrFf > ADDR_ASEL) || (awAddrFf[1:0] != 2'b00);

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            awHeldFf    <= 1'b0;
            wHeldFf     <= 1'b0;
            awAddrFf    <= 8'h00;
            wDataFf     <= 32'h0;
            wStrbFf     <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHeldFf <= 1'b1;
                awAddrFf <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHeldFf <= 1'b1;
                wDataFf <= s_axi_wdata;
                wStrbFf <= s_axi_wstrb;
            end
            if (doWrite)
            begin
                awHeldFf     <= 1'b0;
                wHeldFf      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wrErr ? RESP_SLVERR : RESP_OKAY;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0]  stb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (stb[i])
                r[i*8 +: 8] = dat[i*8 +: 8];
        return r;
    endfunction

    logic [31:0] nxt_ctrl;
    assign nxt_ctrl = merge(ctrlFf, wDataFf, wStrbFf);

    // Configuration registers
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            ctrlFf     <= CTRL_RST;
            hsCfgFf    <= {14'h0, MASK_RST, HSHYST_RST};
            loopTimeFf <= LOOPT_RST;
            loopLbFf   <= {2'h0, LBBAND_RST, 2'h0, LBLEVEL_RST};
            ctrlSelFf  <= {SRC_NONE, SRC_HEAT};
            auxSelFf   <= {SRC_ALM4, SRC_ALM4 - 5'h1, SRC_ALM1 + 5'h1,
                           SRC_ALM1};
        end
        else if (doWrite && !wrErr)
        begin
            case (awAddrFf)
                ADDR_CTRL:
                begin
                    ctrlFf <= nxt_ctrl;
                    if (nxt_ctrl[CTRL_HCOOL] && !ctrlFf[CTRL_HCOOL]
                        && ctrlSelFf[9:5] == SRC_NONE)
                        ctrlSelFf[9:5] <= SRC_COOL;
                    // cooling to aux 4 or aux 2
                    if (nxt_ctrl[CTRL_HCOOL] && !ctrlFf[CTRL_HCOOL]
                        && !nxt_ctrl[CTRL_HASOUT2])
                    begin
                        if (nxt_ctrl[CTRL_AUX4])
                            auxSelFf[19:15] <= SRC_COOL;
                        else
                            auxSelFf[9:5] <= SRC_COOL;
                    end
                    // heater alarm default on aux 1
                    if (nxt_ctrl[CTRL_HBFIT] && !ctrlFf[CTRL_HBFIT]
                        && auxSelFf[4:0] == SRC_ALM1)
                        auxSelFf[4:0] <= SRC_HTR;
                end
                ADDR_HSCFG:
                    hsCfgFf <= merge(hsCfgFf, wDataFf, wStrbFf);
                ADDR_LOOPT:
                    loopTimeFf <= (wDataFf[13:0] > LOOPT_MAX) ? LOOPT_MAX
                                                              : wDataFf[13:0];
                ADDR_LOOPLB:
                    loopLbFf <= merge(loopLbFf, wDataFf, wStrbFf);
                ADDR_CSEL:
                    ctrlSelFf <= wDataFf[9:0];
                ADDR_ASEL:
                    auxSelFf <= wDataFf[19:0];
                default:
                    ctrlFf <= ctrlFf;
            endcase
        end
    end

    // AXI4-Lite read
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            case (s_axi_araddr)
                ADDR_CTRL:   s_axi_rdata <= ctrlFf;
                ADDR_HSCFG:  s_axi_rdata <= hsCfgFf;
                ADDR_LOOPT:  s_axi_rdata <= {18'h0, loopTimeFf};
                ADDR_LOOPLB: s_axi_rdata <= loopLbFf;
                ADDR_CSEL:   s_axi_rdata <= {22'h0, ctrlSelFf};
                ADDR_ASEL:   s_axi_rdata <= {12'h0, auxSelFf};
                ADDR_STATUS: s_axi_rdata <= {24'h0, ctrlOutFf, auxOutFf,
                                             lbFf, latchFf};
                default:
                begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    assign hsUse   = ctrlFf[CTRL_HSUSE];
    assign hsHyst  = (hsCfgFf[9:0] < HSHYST_MIN) ? HSHYST_MIN
                    : (hsCfgFf[9:0] > HS_MAX) ? HS_MAX : hsCfgFf[9:0];
    assign evRole  = ctrlFf[15:10];
    assign outType = ctrlFf[CTRL_OUTTYP +: 6];

    assign hsRaw = hsUse && heaterShortRaw;

    assign clearLatch = (ctrlFf[CTRL_FKEYLAT] && fkSync2Ff[1] && !fkPrevFf)
                      || (ctrlFf[CTRL_EVLAT]
                          && |(evRole & evSync2Ff & ~evPrevFf))
                      || (hsCfgFf[9:0] == HS_MAX);
    assign levelClear = (operLevel >= LVL_INIT) && (operLevel <= LVL_CALIB);

    // set on tick wins over a same-cycle cancel edge; otherwise cancel edges act at once
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            latchFf <= 1'b0;
        else if (levelClear || !hsUse || !ctrlFf[CTRL_LATCH])
            latchFf <= 1'b0;
        else if (sampleTick && hsRaw)
            latchFf <= 1'b1;
        else if (clearLatch)
            latchFf <= 1'b0;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            hsStateFf <= 1'b0;
        else if (!hsUse || levelClear)
            hsStateFf <= 1'b0;
        else if (sampleTick)
        begin
            if (heaterShortRaw)
                hsStateFf <= 1'b1;
            else if (heaterCurrent <= HS_MAX - hsHyst)
                hsStateFf <= 1'b0;
        end
    end

    assign heaterShortAlarm = ctrlFf[CTRL_LATCH] ? latchFf : hsStateFf;

    // only alarm 1 with type 12
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            tickCntFf <= 14'h0;
            secCntFf  <= 14'h0;
            lbRefFf   <= 14'h0;
            lbArmedFf <= 1'b0;
            lbFf      <= 1'b0;
        end
        else if (alarm1Type != LBTYPE || loopTimeFf == 14'h0)
        begin
            tickCntFf <= 14'h0;
            secCntFf  <= 14'h0;
            lbArmedFf <= 1'b0;
            lbFf      <= 1'b0;
        end
        else if (sampleTick)
        begin
            if (tickCntFf == 14'(TICKS_PER_SEC - 1))
            begin
                tickCntFf <= 14'h0;
                if (secCntFf == loopTimeFf - 14'h1)
                begin
                    secCntFf  <= 14'h0;
                    lbRefFf   <= deviation;
                    lbArmedFf <= deviation > loopLbFf[13:0];
                    if (lbArmedFf && deviation > loopLbFf[29:16]
                        && deviation >= lbRefFf)
                        lbFf <= 1'b1;
                    else if (deviation <= loopLbFf[13:0])
                        lbFf <= 1'b0;
                    else
                        lbFf <= lbFf;
                end
                else
                    secCntFf <= secCntFf + 14'h1;
            end
            else
                tickCntFf <= tickCntFf + 14'h1;
        end
    end

    assign loopBreakAlarm = lbFf;

    assign combFlags = {remoteSetpointErrorFlag, inputErrorFlag,
                        heaterShortAlarm, heaterBreakAlarm,
                        alarmIn[3:2], alarmIn[1], alarmIn[0] | lbFf};
    assign combAlarm = |(combFlags & hsCfgFf[17:10]);

    function automatic logic pick(input logic [4:0] sel,
                                  input logic       isCtrl,
                                  input logic       relay);
        logic v;
        v = 1'b0;
        case (sel)
            SRC_NONE:   v = 1'b0;
            SRC_HEAT:   v = heatCtrl;
            SRC_COOL:   v = ctrlFf[CTRL_HCOOL] && coolCtrl;
            SRC_HTR:    v = heaterAlarm;
            SRC_HBRK:   v = heaterBreakAlarm;
            SRC_HSHT:   v = heaterShortAlarm;
            SRC_INERR:  v = inputErrorFlag;
            SRC_RSPERR: v = remoteSetpointErrorFlag;
            SRC_PEND:   v = ctrlFf[CTRL_PROG] && programEnd;
            SRC_RUN:    v = runFlag;
            SRC_COMB:   v = combAlarm;
            default:
            begin
                if (sel >= SRC_ALM1 && sel <= SRC_ALM4)
                    v = (sel == SRC_ALM1) ? (alarmIn[0] | lbFf)
                                          : alarmIn[2'(sel - SRC_ALM1)];
                else if (sel >= SRC_WORK1 && sel <= SRC_WORK8)
                    v = ctrlFf[CTRL_LOGIC]
                        && workBitSource[3'(sel - SRC_WORK1)];
                else
                    v = 1'b0;
            end
        endcase
        // flag sources need relay or voltage
        if (isCtrl && !relay && sel > SRC_COOL)
            v = 1'b0;
        return v;
    endfunction

    // aux outputs select from same list
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            ctrlOutFf <= 2'h0;
            auxOutFf  <= 4'h0;
        end
        else if (sampleTick)
        begin
            for (int c = 0; c < 2; c++)
                ctrlOutFf[c] <= pick(ctrlSelFf[c*5 +: 5], 1'b1,
                                     outType[c]);
            for (int a = 0; a < 4; a++)
                auxOutFf[a] <= pick(auxSelFf[a*5 +: 5], 1'b0, 1'b1);
        end
    end

    assign ctrlOut = ctrlOutFf;
    assign auxOut  = auxOutFf;

    a_latch_level: assert property (@(posedge core_clk) disable iff (!rst_n)
        levelClear |=> !latchFf) else $error("latch not cleared");

    a_latch_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        latchFf && !levelClear && ctrlFf[CTRL_LATCH] && hsUse
        && !clearLatch |=> latchFf)
        else $error("latch dropped");

    a_loop_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
        loopTimeFf == 14'h0 |=> !lbFf) else $error("loop break when off");

    a_hs_unused: assert property (@(posedge core_clk) disable iff (!rst_n)
        !hsUse |=> !latchFf && !hsStateFf) else $error("alarm while unused");

    a_latch_max: assert property (@(posedge core_clk) disable iff (!rst_n)
        sampleTick && !hsRaw && hsCfgFf[9:0] == HS_MAX |=> !latchFf)
        else $error("max current no clear");

    a_loop_type: assert property (@(posedge core_clk) disable iff (!rst_n)
        alarm1Type != LBTYPE |=> !lbFf) else $error("loop break wrong type");

    a_out_stable: assert property (@(posedge core_clk) disable iff (!rst_n)
        !$past(sampleTick) |-> $stable(auxOutFf))
        else $error("aux changed off tick");

    a_cool_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
        sampleTick && !ctrlFf[CTRL_HCOOL] && auxSelFf[4:0] == SRC_COOL
        |=> !auxOutFf[0]) else $error("cooling active");

endmodule // alarm_latch_output_router
`default_nettype wire

// ### sim/heater_sensor_model.sv
`timescale 1ns/1ps
`default_nettype none
module heater_sensor_model (
    input  wire logic       core_clk,
    input  wire logic       shortOn,
    output logic            heaterShortRaw,
    output logic [9:0]      heaterCurrent
);
    // Sensor reports a short one clock after it occurs
    always_ff @(posedge core_clk)
    begin
        heaterShortRaw <= shortOn;
        heaterCurrent  <= shortOn ? 10'h0c8 : 10'h000;
    end
endmodule // heater_sensor_model
`default_nettype wire

// ### sim/tb_alarm_latch_output_router.sv
`timescale 1ns/1ps
`default_nettype none
module tb_alarm_latch_output_router;
    import alarm_router_pkg::*;
    logic core_clk = 0, rst_n = 0, sampleTick = 0, shortOn = 0;
    logic runFlag = 0, functionKey = 0, hsRaw;
    logic [3:0] alarmIn = 0;
    logic [2:0] operLevel = 0;
    logic [9:0] hCur;
    logic [1:0] ctrlOut, bresp, rresp;
    logic [3:0] auxOut;
    logic hsAlarm, awv = 0, awr, wv = 0, wr, bv, br = 0;
    logic arv = 0, arr, rv, rr = 0;
    logic [7:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rd, got;
    logic heatCtrl = 0, coolCtrl = 0, hAlm = 0, hbAlm = 0, inErr = 0;
    logic pEnd = 0, lbAlarm;
    logic [3:0] alm1T = 0;
    logic [5:0] evIn = 0;
    logic [13:0] dev = 0;
    int n_fail = 0, n_checks = 0, i;
    always #2 core_clk = ~core_clk;
    always @(posedge core_clk)
        sampleTick <= ($time / 4) % 4 == 0;
    heater_sensor_model u_heater_sensor_model (.core_clk(core_clk),
        .shortOn(shortOn), .heaterShortRaw(hsRaw), .heaterCurrent(hCur));
    alarm_latch_output_router #(.TICKS_PER_SEC(2)) u_alarm_latch_output_router (
        .core_clk(core_clk), .rst_n(rst_n), .sampleTick(sampleTick),
        .heatCtrl(heatCtrl), .coolCtrl(coolCtrl), .alarmIn(alarmIn),
        .heaterAlarm(hAlm), .heaterBreakAlarm(hbAlm), .heaterShortRaw(hsRaw),
        .inputErrorFlag(inErr), .remoteSetpointErrorFlag(1'b0),
        .programEnd(pEnd), .runFlag(runFlag), .workBitSource(8'h00),
        .heaterCurrent(hCur), .deviation(dev), .alarm1Type(alm1T),
        .operLevel(operLevel), .functionKey(functionKey), .eventIn(evIn),
        .ctrlOut(ctrlOut), .auxOut(auxOut), .heaterShortAlarm(hsAlarm),
        .loopBreakAlarm(lbAlarm), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp),
        .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
        .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        logic aD, wD;
        aD = 0;
        wD = 0;
        awa <= a; wd <= d; awv <= 1; wv <= 1; br <= 1;
        while (!(aD && wD))
        begin
            @(posedge core_clk);
            if (!aD && awr) begin aD = 1; awv <= 0; end
            if (!wD && wr) begin wD = 1; wv <= 0; end
        end
        do @(posedge core_clk); while (!bv);
        br <= 0;
        @(posedge core_clk);
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        ara <= a; arv <= 1; rr <= 1;
        do @(posedge core_clk); while (!arr);
        arv <= 0;
        do @(posedge core_clk); while (!rv);
        d = rd;
        rr <= 0;
        @(posedge core_clk);
    endtask
    task automatic settle();
        repeat (24) @(posedge core_clk);
    endtask
    task automatic trip();
        shortOn <= 1;
        settle();
        shortOn <= 0;
        settle();
    endtask
    task automatic finish_test();
        $display("checks=%0d failures=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        finish_test();
    end
    initial
    begin
        repeat (5) @(posedge core_clk);
        rst_n <= 1;
        rd_reg(ADDR_CTRL, got); chk(got, CTRL_RST);
        rd_reg(ADDR_HSCFG, got); chk(got, 32'h0000c401);
        rd_reg(ADDR_LOOPT, got); chk(got, 32'h0);
        rd_reg(ADDR_LOOPLB, got); chk(got, 32'h001e0050);
        rd_reg(ADDR_CSEL, got); chk(got, 32'h1);
        rd_reg(ADDR_ASEL, got); chk(got, 32'h00031483);
        rd_reg(8'h1c, got); chk({30'h0, rresp}, {30'h0, RESP_SLVERR});
        // Aux outputs follow alarms 1 to 4 by default
        for (i = 0; i < 16; i += 5)
        begin
            alarmIn <= i[3:0];
            settle(); chk({28'h0, auxOut}, i);
        end
        wr_reg(ADDR_CTRL, 32'h00030002);
        wr_reg(ADDR_CSEL, {22'h0, SRC_RUN, SRC_ALM1});
        alarmIn <= 4'h1;
        runFlag <= 1;
        settle(); chk({30'h0, ctrlOut}, 32'h3);
        // Flag sources refused on non relay outputs
        wr_reg(ADDR_CTRL, 32'h00000002);
        settle(); chk({30'h0, ctrlOut}, 32'h0);
        wr_reg(ADDR_CTRL, 32'h00000103);
        trip(); chk({31'h0, hsAlarm}, 32'h1);
        functionKey <= 1;
        settle(); chk({31'h0, hsAlarm}, 32'h0);
        functionKey <= 0;
        trip(); chk({31'h0, hsAlarm}, 32'h1);
        wr_reg(ADDR_HSCFG, 32'h0000c5f4);
        settle(); chk({31'h0, hsAlarm}, 32'h0);
        wr_reg(ADDR_HSCFG, 32'h0000c401);
        trip(); chk({31'h0, hsAlarm}, 32'h1);
        operLevel <= LVL_INIT;
        settle(); chk({31'h0, hsAlarm}, 32'h0);
        // Loop break: deviation above level and band, not shrinking
        alm1T <= LBTYPE;
        dev <= 14'h0100;
        wr_reg(ADDR_LOOPT, 32'h1);
        settle(); chk({31'h0, lbAlarm}, 32'h1);
        dev <= 14'h0000;
        settle(); chk({31'h0, lbAlarm}, 32'h0);
        // Heating/cooling moves control output 2 to cooling
        wr_reg(ADDR_CSEL, {22'h0, SRC_NONE, SRC_HEAT});
        heatCtrl <= 1;
        coolCtrl <= 1;
        wr_reg(ADDR_CTRL, 32'h0003000e);
        rd_reg(ADDR_CSEL, got); chk(got, {22'h0, SRC_COOL, SRC_HEAT});
        settle(); chk({30'h0, ctrlOut}, 32'h3);
        finish_test();
    end
endmodule // tb_alarm_latch_output_router
`default_nettype wire
